// *** logic/pmsb_sideband.sv ***
// How it works
// - root port sends turnoff message on control
// - endpoint control returns turnoff ack upstream
// - root port pulses status on ack received
// - endpoint pulses status on turnoff received
// - a wake request rising edge sends wake when enabled, in endpoint role and with the sequencer idle
// - leave low power first, then send wake
// - wake event tagged with given function number
// - scale codes: unknown, 0.01, 0.001
// - bits 31:24 hold data register value
// - bit 15 shows pending wake regardless enable
// - bits 14:13 scale, read-only
// - bits 12:9 select reported quantity
// - bit 8 enables wake messages
// - bits 1:0 encode D0 to D3
// - D3 plus aux type means cold
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module pmsb_sideband
  import pmsb_pkg::*;
(
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        ARST_N,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // application side
  input  wire logic        TURNOFF_CONTROL,
  output logic             TURNOFF_STATUS,
  input  wire logic        WAKE_EVENT_REQUEST,
  input  wire logic [2:0]  WAKE_EVENT_FUNCTION,
  input  wire logic [9:0]  CONSUMPTION_REPORT,
  input  wire logic        AUX_SUPPLY_FLAG,
  input  wire logic [2:0]  AUX_CURRENT_FIELD,
  // link side message events
  input  wire logic        LINK_TURNOFF_RX,
  input  wire logic        LINK_ACK_RX,
  input  wire logic        LINK_LOW_POWER,
  output logic             LINK_TURNOFF_TX,
  output logic             LINK_ACK_TX,
  output logic             LINK_WAKE_TX,
  output logic [2:0]       LINK_WAKE_FUNC,
  output logic             LINK_EXIT_LOW_POWER
);

  // registers
  logic [1:0]  pstate_reg;
  logic        wake_en_reg;
  logic [3:0]  rsel_reg;
  logic        root_reg;
  logic        aux_type_reg;
  logic        wake_pend_reg;
  logic [7:0]  dsel_reg;
  logic [2:0]  func_reg;
  pmsb_wake_e  wstate_reg;
  pmsb_wake_e  wstate_next;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        tstat_reg;
  logic        tx_off_reg;
  logic        tx_ack_reg;
  logic        tx_wake_reg;
  logic [2:0]  wfunc_reg;
  logic        exit_reg;

  // edge detection
  logic ctl_rise;
  logic wake_rise;
  pmsb_edge u_ctl_edge (
    .CORE_CLK (CORE_CLK),
    .ARST_N   (ARST_N),
    .level_in (TURNOFF_CONTROL),
    .rise_out (ctl_rise)
  );
  pmsb_edge u_wake_edge (
    .CORE_CLK (CORE_CLK),
    .ARST_N   (ARST_N),
    .level_in (WAKE_EVENT_REQUEST),
    .rise_out (wake_rise)
  );

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] r);
    addr_hit = (a == r);
  endfunction

  // apb decode
  wire acc     = PSEL & PENABLE & ~pready_reg;
  wire wr      = acc & PWRITE;
  wire hit_pm  = addr_hit(PADDR, PMSB_ADDR_PMCSR);
  wire hit_ct  = addr_hit(PADDR, PMSB_ADDR_CTRL);
  wire hit_st  = addr_hit(PADDR, PMSB_ADDR_STATUS);
  wire hit_rp  = addr_hit(PADDR, PMSB_ADDR_REPORT);
  wire hit_ds  = addr_hit(PADDR, PMSB_ADDR_DATASEL);
  wire mapped  = hit_pm | hit_ct | hit_st | hit_rp | hit_ds;

  // consumption report fields
  wire [7:0] rpt_val   = CONSUMPTION_REPORT[PMSB_RPT_VAL_HI:PMSB_RPT_VAL_LO];
  wire [1:0] rpt_scale = CONSUMPTION_REPORT[PMSB_RPT_SC_HI:PMSB_RPT_SC_LO];
  wire       rpt_ok    = (AUX_CURRENT_FIELD == 3'h0);
  wire       scale_ok  = (rpt_scale == PMSB_SCALE_CENTI) |
                         (rpt_scale == PMSB_SCALE_MILLI);
  // selection 0 shows the live report while the aux current field is zero, otherwise the data select register
  wire       sel_rpt   = (rsel_reg == {2'h0, PMSB_SEL_REPORT}) & rpt_ok;
  wire [7:0] data_fld  = sel_rpt ? rpt_val : dsel_reg;
  wire [1:0] scale_fld = (sel_rpt & scale_ok) ? rpt_scale : PMSB_SCALE_UNKNOWN;

  wire       low_pwr   = (pstate_reg != PMSB_D0) | LINK_LOW_POWER;
  wire       d3        = (pstate_reg == PMSB_D3);
  wire       d3_cold   = d3 & aux_type_reg;
  wire       d3_hot    = d3 & ~aux_type_reg;

  wire [31:0] pm_word = {data_fld, PMSB_ZERO8, wake_pend_reg, scale_fld, rsel_reg,
                         wake_en_reg, 6'h00, pstate_reg};
  wire [31:0] st_word = {21'h0, func_reg, 2'h0, rpt_ok, AUX_SUPPLY_FLAG,
                         (wstate_reg != PMSB_W_IDLE), d3_hot, d3_cold, low_pwr};
  wire [31:0] ct_word = {30'h0, aux_type_reg, root_reg};
  wire [31:0] rp_word = {22'h0, CONSUMPTION_REPORT};
  wire [31:0] ds_word = {24'h0, dsel_reg};
  wire [31:0] rd_mux  = hit_pm ? pm_word :
                        hit_ct ? ct_word :
                        hit_st ? st_word :
                        hit_rp ? rp_word :
                        hit_ds ? ds_word : PMSB_ZERO32;

  // wake request qualifies only in endpoint role, with enable
  wire wake_req  = wake_rise & ~root_reg;
  wire wake_go   = wake_req & wake_en_reg;
  wire idle      = (wstate_reg == PMSB_W_IDLE);
  // clear by software write of one; a new event wins over the clear
  wire pend_clr  = wr & hit_pm & PWDATA[PMSB_WPEND_BIT];

  always_comb begin
    wstate_next = wstate_reg;
    case (wstate_reg)
      PMSB_W_IDLE: begin
        if (wake_go) begin
          wstate_next = LINK_LOW_POWER ? PMSB_W_EXIT : PMSB_W_SEND;
        end
      end
      PMSB_W_EXIT: begin
        if (!LINK_LOW_POWER) begin
          wstate_next = PMSB_W_SEND;
        end
      end
      PMSB_W_SEND: wstate_next = PMSB_W_IDLE;
      default: wstate_next = PMSB_W_IDLE;
    endcase
  end

  // wake sequencer and message outputs
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wstate_reg  <= PMSB_W_IDLE;
      tx_wake_reg <= 1'b0;
      wfunc_reg   <= 3'h0;
      exit_reg    <= 1'b0;
      func_reg    <= 3'h0;
    end else begin
      wstate_reg  <= wstate_next;
      tx_wake_reg <= (wstate_reg == PMSB_W_SEND);
      exit_reg    <= (wstate_next == PMSB_W_EXIT);
      if (idle && wake_go) begin
        func_reg <= WAKE_EVENT_FUNCTION;
      end
      if (wstate_reg == PMSB_W_SEND) begin
        wfunc_reg <= func_reg;
      end
    end
  end

  // turn-off handshake
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tx_off_reg <= 1'b0;
      tx_ack_reg <= 1'b0;
      tstat_reg  <= 1'b0;
    end else begin
      tx_off_reg <= ctl_rise & root_reg;
      tx_ack_reg <= ctl_rise & ~root_reg;
      tstat_reg  <= root_reg ? LINK_ACK_RX : LINK_TURNOFF_RX;
    end
  end

  // software registers
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pstate_reg    <= PMSB_D0;
      wake_en_reg   <= 1'b0;
      rsel_reg      <= 4'h0;
      root_reg      <= 1'b0;
      aux_type_reg  <= 1'b0;
      dsel_reg      <= 8'h00;
      wake_pend_reg <= 1'b0;
    end else begin
      if (wr && hit_pm) begin
        pstate_reg  <= PWDATA[PMSB_PST_HI:PMSB_PST_LO];
        wake_en_reg <= PWDATA[PMSB_WEN_BIT];
        rsel_reg    <= PWDATA[PMSB_RSEL_HI:PMSB_RSEL_LO];
      end
      if (wr && hit_ct) begin
        root_reg     <= PWDATA[PMSB_CTRL_ROOT_BIT];
        aux_type_reg <= PWDATA[PMSB_CTRL_AUXTY_BIT];
      end
      if (wr && hit_ds) begin
        dsel_reg <= PWDATA[7:0];
      end
      if (wake_req) begin
        wake_pend_reg <= 1'b1;
      end else if (pend_clr) begin
        wake_pend_reg <= 1'b0;
      end
    end
  end

  // apb answer one cycle into the access phase
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= PMSB_ZERO32;
    end else begin
      pready_reg  <= acc;
      pslverr_reg <= acc & ~mapped;
      prdata_reg  <= (acc & ~PWRITE) ? rd_mux : PMSB_ZERO32;
    end
  end

  assign PRDATA              = prdata_reg;
  assign PREADY              = pready_reg;
  assign PSLVERR             = pslverr_reg;
  assign TURNOFF_STATUS      = tstat_reg;
  assign LINK_TURNOFF_TX     = tx_off_reg;
  assign LINK_ACK_TX         = tx_ack_reg;
  assign LINK_WAKE_TX        = tx_wake_reg;
  assign LINK_WAKE_FUNC      = wfunc_reg;
  assign LINK_EXIT_LOW_POWER = exit_reg;

  // checks
  property p_root_off;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      (ctl_rise && root_reg) |=> LINK_TURNOFF_TX;
  endproperty
  a_root_off: assert property (p_root_off) else $error("turnoff not sent");

  property p_ep_ack;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      (ctl_rise && !root_reg) |=> (LINK_ACK_TX && !LINK_TURNOFF_TX);
  endproperty
  a_ep_ack: assert property (p_ep_ack) else $error("ack not sent");

  property p_root_stat;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      (root_reg && LINK_ACK_RX && !$past(LINK_ACK_RX)) |=> TURNOFF_STATUS;
  endproperty
  a_root_stat: assert property (p_root_stat) else $error("status missing");

  property p_ep_stat;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      (!root_reg && LINK_TURNOFF_RX) |=> TURNOFF_STATUS;
  endproperty
  a_ep_stat: assert property (p_ep_stat) else $error("status missing");

  sequence s_wake_go;
    idle && wake_go && !LINK_LOW_POWER;
  endsequence
  property p_wake;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      s_wake_go |=> ##1 LINK_WAKE_TX;
  endproperty
  a_wake: assert property (p_wake) else $error("wake not sent");

  property p_exit_first;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      $rose(LINK_WAKE_TX) |-> !$past(LINK_LOW_POWER, 2);
  endproperty
  a_exit_first: assert property (p_exit_first) else $error("wake in low power");

  property p_wen;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      (idle && !wake_en_reg) |=> (wstate_reg == PMSB_W_IDLE);
  endproperty
  a_wen: assert property (p_wen) else $error("wake while disabled");

  property p_pend;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      wake_req |=> wake_pend_reg;
  endproperty
  a_pend: assert property (p_pend) else $error("pending lost");

  property p_one;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      LINK_WAKE_TX |=> !LINK_WAKE_TX;
  endproperty
  a_one: assert property (p_one) else $error("double wake");

  // the exit request stands while the link is still asleep
  sequence s_exit_wait;
    (wstate_reg == PMSB_W_EXIT) && LINK_LOW_POWER;
  endsequence
  property p_exit_hold;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      s_exit_wait |=> LINK_EXIT_LOW_POWER;
  endproperty
  a_exit_hold: assert property (p_exit_hold) else $error("exit request dropped");

  property p_func;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      s_wake_go |=> ##1 (LINK_WAKE_FUNC == $past(WAKE_EVENT_FUNCTION, 2));
  endproperty
  a_func: assert property (p_func) else $error("wake function wrong");

  property p_root_quiet;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      (idle && root_reg) |=> (wstate_reg == PMSB_W_IDLE);
  endproperty
  a_root_quiet: assert property (p_root_quiet) else $error("wake in root role");

  property p_stat_pulse;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      TURNOFF_STATUS |=> !TURNOFF_STATUS;
  endproperty
  a_stat_pulse: assert property (p_stat_pulse) else $error("status too long");

  property p_one_off;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      LINK_TURNOFF_TX |=> !LINK_TURNOFF_TX;
  endproperty
  a_one_off: assert property (p_one_off) else $error("double turnoff");

endmodule
`default_nettype wire

// *** pkg/pmsb_pkg.sv ***
`default_nettype none
package pmsb_pkg;
  // apb register map (byte addresses)
  localparam logic [7:0] PMSB_ADDR_PMCSR   = 8'h00;
  localparam logic [7:0] PMSB_ADDR_CTRL    = 8'h04;
  localparam logic [7:0] PMSB_ADDR_STATUS  = 8'h08;
  localparam logic [7:0] PMSB_ADDR_REPORT  = 8'h0c;
  localparam logic [7:0] PMSB_ADDR_DATASEL = 8'h10;
  // power management register fields
  localparam int PMSB_DATA_HI   = 31;
  localparam int PMSB_DATA_LO   = 24;
  localparam int PMSB_WPEND_BIT = 15;
  localparam int PMSB_SCALE_HI  = 14;
  localparam int PMSB_SCALE_LO  = 13;
  localparam int PMSB_RSEL_HI   = 12;
  localparam int PMSB_RSEL_LO   = 9;
  localparam int PMSB_WEN_BIT   = 8;
  localparam int PMSB_PST_HI    = 1;
  localparam int PMSB_PST_LO    = 0;
  // consumption report layout
  localparam int PMSB_RPT_VAL_HI = 9;
  localparam int PMSB_RPT_VAL_LO = 2;
  localparam int PMSB_RPT_SC_HI  = 1;
  localparam int PMSB_RPT_SC_LO  = 0;
  // scale codes
  localparam logic [1:0] PMSB_SCALE_UNKNOWN = 2'h0;
  localparam logic [1:0] PMSB_SCALE_CENTI   = 2'h2;
  localparam logic [1:0] PMSB_SCALE_MILLI   = 2'h3;
  // power states
  localparam logic [1:0] PMSB_D0 = 2'h0;
  localparam logic [1:0] PMSB_D1 = 2'h1;
  localparam logic [1:0] PMSB_D2 = 2'h2;
  localparam logic [1:0] PMSB_D3 = 2'h3;
  // ctrl register bits
  localparam int PMSB_CTRL_ROOT_BIT  = 0;
  localparam int PMSB_CTRL_AUXTY_BIT = 1;
  // status register bits
  localparam int PMSB_ST_LOWPWR_BIT = 0;
  localparam int PMSB_ST_D3COLD_BIT = 1;
  localparam int PMSB_ST_D3HOT_BIT  = 2;
  localparam int PMSB_ST_BUSY_BIT   = 3;
  localparam int PMSB_ST_AUX_BIT    = 4;
  localparam int PMSB_ST_RPTOK_BIT  = 5;
  localparam int PMSB_ST_FN_LO      = 8;
  localparam int PMSB_ST_FN_HI      = 10;
  localparam logic [1:0] PMSB_SEL_REPORT = 2'h0;
  localparam logic [31:0] PMSB_ZERO32 = 32'h0;
  localparam logic [7:0]  PMSB_ZERO8  = 8'h0;
  // wake sequencer states, gray from idle through exit to send
  typedef enum logic [1:0] {
    PMSB_W_IDLE = 2'b00,
    PMSB_W_EXIT = 2'b01,
    PMSB_W_SEND = 2'b11
  } pmsb_wake_e;
endpackage
`default_nettype wire

// *** logic/pmsb_edge.sv ***
`timescale 1ns/100ps
`default_nettype none
module pmsb_edge (
  // clock and reset
  input  wire logic CORE_CLK,
  input  wire logic ARST_N,
  // level in, pulse out
  input  wire logic level_in,
  output logic      rise_out
);
  logic prev_reg;
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= level_in;
    end
  end
  assign rise_out = level_in & ~prev_reg;
endmodule
`default_nettype wire

// *** dv/pmsb_link_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module pmsb_link_model #(
  parameter int EXIT_DLY = 3
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // from the device under test
  input  wire logic turnoff_tx,
  input  wire logic exit_req,
  // bench controls
  input  wire logic sleep_req,
  input  wire logic off_req,
  // to the device under test
  output logic      ack_rx,
  output logic      turnoff_rx,
  output logic      low_power
);
  logic [1:0] ack_dly;
  int         exit_cnt;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_dly    <= 2'h0;
      ack_rx     <= 1'b0;
      turnoff_rx <= 1'b0;
      low_power  <= 1'b0;
      exit_cnt   <= 0;
    end else begin
      // downstream side answers a turnoff some cycles later
      ack_dly    <= {ack_dly[0], turnoff_tx};
      ack_rx     <= ack_dly[1];
      turnoff_rx <= off_req;
      if (sleep_req) begin
        low_power <= 1'b1;
      end else if (exit_req && low_power) begin
        // slow to leave low power, so an early wake would show
        exit_cnt <= exit_cnt + 1;
        if (exit_cnt == EXIT_DLY) begin
          low_power <= 1'b0;
          exit_cnt  <= 0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** dv/pmsb_sideband_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module pmsb_sideband_tb_top;
  import pmsb_pkg::*;
  logic clk = 1'b0, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic tctl, tstat, wreq, auxf, ack_rx, off_rx, lowp, off_tx, ack_tx, wake_tx, exit_lp;
  logic er, sleep, offq, early = 1'b0;
  logic [2:0] wfunc, auxc, wfn, lfunc;
  logic [9:0] report;
  int failures = 0, n_tests = 0, ca, cb;
  always #10 clk = ~clk;
  pmsb_sideband pmsb_sideband_inst (.CORE_CLK(clk), .ARST_N(arst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .TURNOFF_CONTROL(tctl), .TURNOFF_STATUS(tstat),
    .WAKE_EVENT_REQUEST(wreq), .WAKE_EVENT_FUNCTION(wfunc), .CONSUMPTION_REPORT(report),
    .AUX_SUPPLY_FLAG(auxf), .AUX_CURRENT_FIELD(auxc), .LINK_TURNOFF_RX(off_rx),
    .LINK_ACK_RX(ack_rx), .LINK_LOW_POWER(lowp), .LINK_TURNOFF_TX(off_tx),
    .LINK_ACK_TX(ack_tx), .LINK_WAKE_TX(wake_tx), .LINK_WAKE_FUNC(lfunc),
    .LINK_EXIT_LOW_POWER(exit_lp));
  pmsb_link_model pmsb_link_model_inst (.clk(clk), .arst_n(arst_n), .turnoff_tx(off_tx),
    .exit_req(exit_lp), .sleep_req(sleep), .off_req(offq), .ack_rx(ack_rx),
    .turnoff_rx(off_rx), .low_power(lowp));
  always @(posedge clk) begin
    if (wake_tx) wfn <= lfunc;
    if (wake_tx && lowp) early <= 1'b1;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) chk(32'(pready), 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // counts high cycles of two outputs over a window
  task automatic cnt(ref logic a, ref logic b, input int n);
    ca = 0; cb = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      ca += int'(a); cb += int'(b);
    end
  endtask
  task automatic t_regs;
    chk(32'({tstat, off_tx, ack_tx, wake_tx, exit_lp, pready, pslverr}), 32'h0);
    apb(1'b1, PMSB_ADDR_PMCSR, 32'hffffffff);
    apb(1'b0, PMSB_ADDR_PMCSR, 32'h0);
    chk(rd & 32'h00ff00fc, 32'h0);
    chk(32'(rd[15:0]), 32'h1f03);
    apb(1'b0, 8'h20, 32'h0);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, PMSB_ADDR_PMCSR, 32'h0);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) report <= {8'h72, 2'(i)};
      apb(1'b0, PMSB_ADDR_PMCSR, 32'h0);
      chk(32'(rd[31:24]), 32'h72);
      chk(32'(rd[14:13]), (i == 1) ? 32'h0 : 32'(i));
    end
    apb(1'b0, PMSB_ADDR_REPORT, 32'h0);
    chk(rd, 32'h1cb);
    @(posedge clk) auxc <= 3'h1;
    apb(1'b0, PMSB_ADDR_PMCSR, 32'h0);
    chk(32'({rd[31:24], rd[14:13]}), 32'h0);
    apb(1'b0, PMSB_ADDR_STATUS, 32'h0);
    chk(32'(rd[5:4]), 32'h0);
    @(posedge clk) auxc <= 3'h0;
    apb(1'b1, PMSB_ADDR_DATASEL, 32'h5a);
    apb(1'b1, PMSB_ADDR_PMCSR, 32'h200);
    apb(1'b0, PMSB_ADDR_PMCSR, 32'h0);
    chk(32'({rd[31:24], rd[14:13], rd[12:9]}), 32'h1681);
  endtask
  task automatic t_turnoff;
    apb(1'b1, PMSB_ADDR_CTRL, 32'h1);
    @(posedge clk) tctl <= 1'b1;
    cnt(off_tx, tstat, 10);
    chk(32'({ca[3:0], cb[3:0]}), 32'h11);
    @(posedge clk) tctl <= 1'b0;
    apb(1'b1, PMSB_ADDR_CTRL, 32'h0);
    @(posedge clk) offq <= 1'b1;
    @(posedge clk) offq <= 1'b0;
    cnt(tstat, ack_tx, 6);
    chk(32'({ca[3:0], cb[3:0]}), 32'h10);
    @(posedge clk) tctl <= 1'b1;
    cnt(ack_tx, off_tx, 6);
    chk(32'({ca[3:0], cb[3:0]}), 32'h10);
    @(posedge clk) tctl <= 1'b0;
  endtask
  task automatic t_wake;
    apb(1'b1, PMSB_ADDR_PMCSR, 32'h100);
    @(posedge clk) begin
      wfunc <= 3'h5;
      wreq <= 1'b1;
    end
    cnt(wake_tx, exit_lp, 8);
    chk(32'({ca[3:0], cb[3:0], 1'b0, wfn}), 32'h105);
    @(posedge clk) wreq <= 1'b0;
    apb(1'b0, PMSB_ADDR_PMCSR, 32'h0);
    chk(32'(rd[15]), 32'h1);
    apb(1'b1, PMSB_ADDR_PMCSR, 32'h8000);
    apb(1'b0, PMSB_ADDR_PMCSR, 32'h0);
    chk(32'(rd[15]), 32'h0);
    @(posedge clk) wreq <= 1'b1;
    cnt(wake_tx, exit_lp, 8);
    chk(32'(ca), 32'h0);
    @(posedge clk) wreq <= 1'b0;
    apb(1'b0, PMSB_ADDR_PMCSR, 32'h0);
    chk(32'(rd[15]), 32'h1);
    apb(1'b1, PMSB_ADDR_PMCSR, 32'h8100);
    @(posedge clk) sleep <= 1'b1;
    @(posedge clk) begin
      sleep <= 1'b0;
      wreq <= 1'b1;
    end
    cnt(wake_tx, exit_lp, 20);
    chk(32'({ca[3:0], early, cb > 0}), 32'h5);
    @(posedge clk) wreq <= 1'b0;
  endtask
  task automatic t_dstate;
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, PMSB_ADDR_PMCSR, 32'(s));
      apb(1'b0, PMSB_ADDR_PMCSR, 32'h0);
      chk(32'(rd[1:0]), 32'(s));
    end
    for (int t = 0; t < 2; t++) begin
      apb(1'b1, PMSB_ADDR_CTRL, 32'(2 * t));
      apb(1'b0, PMSB_ADDR_STATUS, 32'h0);
      chk(32'(rd[2:1]), (t == 1) ? 32'h1 : 32'h2);
    end
    apb(1'b0, PMSB_ADDR_CTRL, 32'h0);
    chk(rd, 32'h2);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #(20 * 4000);
    failures++;
    results;
  end
  initial begin
    arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0;
    pwdata = 32'h0; tctl = 1'b0; wreq = 1'b0; wfunc = 3'h0; report = 10'h0;
    auxf = 1'b0; auxc = 3'h0; sleep = 1'b0; offq = 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    t_regs;
    t_turnoff;
    t_wake;
    t_dstate;
    results;
  end
endmodule
`default_nettype wire
